/* core/dsio_pkg.sv */
package dsio_pkg;
	localparam int DSIO_DATA_W = 8;
	localparam int DSIO_ADDR_W = 21;
	localparam int DSIO_LANE_W = 4;
	localparam int DSIO_CAL_CYCLES = 1024;
	localparam int DSIO_RELOCK_CYCLES = 1024;
	localparam int DSIO_CLK_MISS_CYC = 8;
	localparam int DSIO_FIFO_DEPTH = 32;
	localparam logic DSIO_RW_READ = 1'b1;
	localparam logic DSIO_RW_WRITE = 1'b0;
	localparam logic DSIO_WORD_LO = 1'b0;
	localparam logic DSIO_WORD_HI = 1'b1;

	// Active-low lane masks: a low bit lets its lane through
	function automatic logic [DSIO_DATA_W-1:0] dsio_merge(
		input logic [DSIO_DATA_W-1:0] old_v,
		input logic [DSIO_DATA_W-1:0] new_v,
		input logic [DSIO_DATA_W/DSIO_LANE_W-1:0] mask_n);
		logic [DSIO_DATA_W-1:0] r;
		r = old_v;
		for (int i = 0; i < DSIO_DATA_W / DSIO_LANE_W; i++)
		begin
			if (!mask_n[i])
				r[i*DSIO_LANE_W +: DSIO_LANE_W] = new_v[i*DSIO_LANE_W +: DSIO_LANE_W];
		end
		return r;
	endfunction : dsio_merge
endpackage : dsio_pkg

/* core/dsio_if.sv */
`timescale 1ns/1ps
interface dsio_if
	import dsio_pkg::*;
();
	logic k;
	logic k_n;
	logic c;
	logic c_n;
	logic load_select_n;
	logic rw;
	logic [DSIO_ADDR_W-1:0] addr;
	logic [DSIO_DATA_W-1:0] wdata;
	logic [DSIO_DATA_W/DSIO_LANE_W-1:0] nibble_write_mask_n;
	logic [DSIO_DATA_W-1:0] rdata;
	logic rdata_oe;
	logic echo_clock_true;
	logic echo_clock_comp;

	modport device (
		input k, k_n, c, c_n, load_select_n, rw, addr, wdata, nibble_write_mask_n,
		output rdata, rdata_oe, echo_clock_true, echo_clock_comp
	);
	modport host (
		output k, k_n, c, c_n, load_select_n, rw, addr, wdata, nibble_write_mask_n,
		input rdata, rdata_oe, echo_clock_true, echo_clock_comp
	);
endinterface : dsio_if

/* core/dsio_fifo.sv */
`timescale 1ns/1ps
module dsio_fifo
	import dsio_pkg::*;
#(
	parameter int WIDTH = 2 * DSIO_DATA_W,
	parameter int DEPTH = DSIO_FIFO_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
	} dsio_fifo_st_t;

	dsio_fifo_st_t q;
	dsio_fifo_st_t d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign in_ready_o = (q.cnt != CW'(DEPTH));
	assign out_valid_o = (q.cnt != '0);
	assign out_data_o = mem[q.rd];
	assign count_o = q.cnt;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_comb
	begin
		d = q;
		if (push)
			d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
		if (pop)
			d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
		d.cnt = q.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			q <= '0;
		else
			q <= d;
		if (push)
			mem[q.wr] <= in_data_i;
	end
endmodule : dsio_fifo

/* core/dsio_host.sv */
`timescale 1ns/1ps
module dsio_host
	import dsio_pkg::*;
#(
	parameter bit USE_OUT_CLK = 1'b1,
	parameter int DEPTH = DSIO_FIFO_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	dsio_if.host bus,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_write_i,
	input wire logic [DSIO_ADDR_W-1:0] cmd_addr_i,
	input wire logic [DSIO_DATA_W-1:0] cmd_wdata0_i,
	input wire logic [DSIO_DATA_W-1:0] cmd_wdata1_i,
	input wire logic [DSIO_DATA_W/DSIO_LANE_W-1:0] cmd_mask0_n_i,
	input wire logic [DSIO_DATA_W/DSIO_LANE_W-1:0] cmd_mask1_n_i,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [2*DSIO_DATA_W-1:0] rd_data_o
);
	localparam int MW = DSIO_DATA_W / DSIO_LANE_W;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic k;
		logic ld_n;
		logic rw;
		logic [DSIO_ADDR_W-1:0] addr;
		logic [DSIO_DATA_W-1:0] wdata;
		logic [MW-1:0] mask_n;
		logic hold_v;
		logic [DSIO_DATA_W-1:0] hold_w0;
		logic [DSIO_DATA_W-1:0] hold_w1;
		logic [MW-1:0] hold_m0;
		logic [MW-1:0] hold_m1;
		logic [DSIO_DATA_W-1:0] cur_w1;
		logic [MW-1:0] cur_m1;
		logic eq_t_prev;
		logic eq_c_prev;
		logic [DSIO_DATA_W-1:0] r_w0;
		logic push_v;
		logic [2*DSIO_DATA_W-1:0] push_data;
		logic [CW-1:0] outst;
	} dsio_host_st_t;

	dsio_host_st_t q;
	dsio_host_st_t d;
	logic fifo_ready;
	logic [CW-1:0] fifo_cnt;
	logic room;
	logic fire;
	logic pushed;

	// Reads only go out with space reserved, so the fifo can never overflow
	assign room = ({1'b0, fifo_cnt} + {1'b0, q.outst}) < (CW + 1)'(DEPTH);
	assign cmd_ready_o = ~q.k & (cmd_write_i | room);
	assign fire = cmd_valid_i & cmd_ready_o;
	assign pushed = q.push_v & fifo_ready;

	always_comb
	begin
		d = q;
		d.eq_t_prev = bus.echo_clock_true;
		d.eq_c_prev = bus.echo_clock_comp;
		if (!q.k)
		begin
			d.k = 1'b1;
			d.ld_n = ~fire;
			d.rw = cmd_write_i ? DSIO_RW_WRITE : DSIO_RW_READ;
			d.addr = cmd_addr_i;
			d.wdata = q.hold_w0;
			d.mask_n = q.hold_v ? q.hold_m0 : '1;
			d.cur_w1 = q.hold_w1;
			d.cur_m1 = q.hold_v ? q.hold_m1 : '1;
			d.hold_v = fire & cmd_write_i;
			d.hold_w0 = cmd_wdata0_i;
			d.hold_w1 = cmd_wdata1_i;
			d.hold_m0 = cmd_mask0_n_i;
			d.hold_m1 = cmd_mask1_n_i;
		end
		else
		begin
			d.k = 1'b0;
			d.ld_n = 1'b1;
			d.wdata = q.cur_w1;
			d.mask_n = q.cur_m1;
		end
		if (bus.rdata_oe && bus.echo_clock_comp && !q.eq_c_prev)
			d.r_w0 = bus.rdata;
		if (pushed)
			d.push_v = 1'b0;
		if (bus.rdata_oe && bus.echo_clock_true && !q.eq_t_prev)
		begin
			d.push_v = 1'b1;
			d.push_data = {bus.rdata, q.r_w0};
		end
		d.outst = q.outst + CW'(fire & ~cmd_write_i) - CW'(pushed);
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.ld_n <= 1'b1;
			q.mask_n <= '1;
			q.cur_m1 <= '1;
		end
		else
			q <= d;
	end

	assign bus.k = q.k;
	assign bus.k_n = ~q.k;
	assign bus.c = USE_OUT_CLK ? q.k : 1'b1;
	assign bus.c_n = USE_OUT_CLK ? ~q.k : 1'b1;
	assign bus.load_select_n = q.ld_n;
	assign bus.rw = q.rw;
	assign bus.addr = q.addr;
	assign bus.wdata = q.wdata;
	assign bus.nibble_write_mask_n = q.mask_n;

	dsio_fifo #(
		.WIDTH(2 * DSIO_DATA_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_valid_i(q.push_v),
		.in_ready_o(fifo_ready),
		.in_data_i(q.push_data),
		.out_valid_o(rd_valid_o),
		.out_ready_i(rd_ready_i),
		.out_data_o(rd_data_o),
		.count_o(fifo_cnt)
	);
endmodule : dsio_host

/* core/dsio_device.sv */
`timescale 1ns/1ps
// Contract
// - Address captured at true clock rise
// - Low word first, then high word
// - Only asserted load select starts transaction
// - Write data and masks on both edges
// - Read outputs clocked by output clocks
// - Read word one after next comp rise
// - Tied output clocks never toggle
// - Outputs released when no read data
// - Any command every cycle, no gap
// - Write data follows at next cycle
// - Read after write sees new data
// - Each transaction is one full cycle
// - Active-low lane masks with their word
// - Impedance calibration takes fixed cycle count
// - DLL resets on missing clock, relocks
// - Echo clocks antiphase from output edge
// - Low mask low nibble, high mask high
module dsio_device
	import dsio_pkg::*;
#(
	parameter int ADDR_W = DSIO_ADDR_W,
	parameter int CAL_CYCLES = DSIO_CAL_CYCLES,
	parameter int RELOCK_CYCLES = DSIO_RELOCK_CYCLES,
	parameter int MISS_CYC = DSIO_CLK_MISS_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	dsio_if.device bus,
	output logic cal_done_o,
	output logic dll_locked_o
);
	localparam int MW = DSIO_DATA_W / DSIO_LANE_W;
	localparam int CALW = $clog2(CAL_CYCLES + 1);
	localparam int DLLW = $clog2(RELOCK_CYCLES + 1);
	localparam int MISW = $clog2(MISS_CYC + 1);

	typedef struct packed {
		logic k_prev;
		logic kn_prev;
		logic c_prev;
		logic cn_prev;
		logic s_v;
		logic [ADDR_W-1:0] s_addr;
		logic a_v;
		logic [ADDR_W-1:0] a_addr;
		logic [DSIO_DATA_W-1:0] a_w0;
		logic [MW-1:0] a_m0;
		logic p_v;
		logic [ADDR_W-1:0] p_addr;
		logic [DSIO_DATA_W-1:0] p_w0;
		logic [DSIO_DATA_W-1:0] p_w1;
		logic [MW-1:0] p_m0;
		logic [MW-1:0] p_m1;
		logic r1_v;
		logic [ADDR_W-1:0] r1_addr;
		logic r2_v;
		logic [ADDR_W-1:0] r2_addr;
		logic [DSIO_DATA_W-1:0] rdata;
		logic oe;
		logic eq_t;
		logic eq_c;
		logic [CALW-1:0] cal_cnt;
		logic cal_done;
		logic [MISW-1:0] miss_cnt;
		logic [DLLW-1:0] dll_cnt;
		logic dll_locked;
	} dsio_dev_st_t;

	dsio_dev_st_t q;
	dsio_dev_st_t d;
	logic [DSIO_DATA_W-1:0] mem [2**(ADDR_W+1)];
	logic k_rise;
	logic kn_rise;
	logic use_c;
	logic o_rise;
	logic o_fall;
	logic commit;
	logic [DSIO_DATA_W-1:0] lo_v;
	logic [DSIO_DATA_W-1:0] hi_v;

	assign k_rise = bus.k & ~q.k_prev;
	assign kn_rise = bus.k_n & ~q.kn_prev;
	// Both output clocks held high selects single-clock mode
	assign use_c = ~(bus.c & bus.c_n);
	assign o_rise = use_c ? (bus.c & ~q.c_prev) : k_rise;
	assign o_fall = use_c ? (bus.c_n & ~q.cn_prev) : kn_rise;
	// Staged write lands in the array once the next write burst is complete
	assign commit = kn_rise & q.a_v & q.p_v;

	always_comb
	begin
		lo_v = mem[{q.r2_addr, DSIO_WORD_LO}];
		hi_v = mem[{q.r2_addr, DSIO_WORD_HI}];
		// Newest data wins: register beats staged word beats array
		if (q.p_v && q.p_addr == q.r2_addr)
		begin
			lo_v = dsio_merge(lo_v, q.p_w0, q.p_m0);
			hi_v = dsio_merge(hi_v, q.p_w1, q.p_m1);
		end
		if (q.a_v && q.a_addr == q.r2_addr)
			lo_v = dsio_merge(lo_v, q.a_w0, q.a_m0);
	end

	always_comb
	begin
		d = q;
		d.k_prev = bus.k;
		d.kn_prev = bus.k_n;
		d.c_prev = bus.c;
		d.cn_prev = bus.c_n;
		if (k_rise)
		begin
			// New command taken every cycle regardless of the last one
			d.s_v = ~bus.load_select_n & (bus.rw == DSIO_RW_WRITE);
			d.s_addr = bus.addr[ADDR_W-1:0];
			d.r1_v = ~bus.load_select_n & (bus.rw == DSIO_RW_READ);
			d.r1_addr = bus.addr[ADDR_W-1:0];
			d.r2_v = q.r1_v;
			d.r2_addr = q.r1_addr;
			d.a_v = q.s_v;
			d.a_addr = q.s_addr;
			d.a_w0 = bus.wdata;
			d.a_m0 = bus.nibble_write_mask_n;
			d.miss_cnt = '0;
			if (!q.cal_done)
			begin
				d.cal_cnt = q.cal_cnt + 1'b1;
				d.cal_done = (q.cal_cnt == CALW'(CAL_CYCLES - 1));
			end
			if (!q.dll_locked)
			begin
				d.dll_cnt = q.dll_cnt + 1'b1;
				d.dll_locked = (q.dll_cnt == DLLW'(RELOCK_CYCLES - 1));
			end
		end
		else if (q.miss_cnt == MISW'(MISS_CYC))
		begin
			d.dll_locked = 1'b0;
			d.dll_cnt = '0;
		end
		else if (!kn_rise)
			d.miss_cnt = q.miss_cnt + 1'b1;
		else
			d.miss_cnt = '0;
		if (kn_rise && q.a_v)
		begin
			d.p_v = 1'b1;
			d.p_addr = q.a_addr;
			d.p_w0 = q.a_w0;
			d.p_m0 = q.a_m0;
			d.p_w1 = bus.wdata;
			d.p_m1 = bus.nibble_write_mask_n;
			d.a_v = 1'b0;
		end
		if (o_rise)
		begin
			d.eq_t = 1'b1;
			d.eq_c = 1'b0;
			if (q.r2_v)
				d.rdata = hi_v;
		end
		if (o_fall)
		begin
			d.eq_t = 1'b0;
			d.eq_c = 1'b1;
			d.oe = d.r2_v;
			if (d.r2_v)
				d.rdata = lo_v;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			q <= '0;
		else
			q <= d;
		if (commit)
		begin
			mem[{q.p_addr, DSIO_WORD_LO}] <= dsio_merge(mem[{q.p_addr, DSIO_WORD_LO}], q.p_w0, q.p_m0);
			mem[{q.p_addr, DSIO_WORD_HI}] <= dsio_merge(mem[{q.p_addr, DSIO_WORD_HI}], q.p_w1, q.p_m1);
		end
	end

	// All-zero data is driven onto the bus while released
	assign bus.rdata = q.oe ? q.rdata : '0;
	assign bus.rdata_oe = q.oe;
	assign bus.echo_clock_true = q.eq_t;
	assign bus.echo_clock_comp = q.eq_c;
	assign cal_done_o = q.cal_done;
	assign dll_locked_o = q.dll_locked;
endmodule : dsio_device

/* tb/dsio_assertions.sv */
`timescale 1ns/1ps
module dsio_assertions
	import dsio_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic k,
	input wire logic k_n,
	input wire logic c,
	input wire logic load_select_n,
	input wire logic rw,
	input wire logic [DSIO_DATA_W/DSIO_LANE_W-1:0] nibble_write_mask_n,
	input wire logic [DSIO_DATA_W-1:0] rdata,
	input wire logic rdata_oe,
	input wire logic echo_clock_true,
	input wire logic echo_clock_comp
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	logic rd_go;
	logic wr_go;
	// Select only valid while k high, so no past term needed
	assign rd_go = k && !load_select_n && rw;
	assign wr_go = k && !load_select_n && !rw;
	rd_latency_a: assert property (rd_go |-> ##4 rdata_oe ##1 rdata_oe) else $error("read late");
	oe_cause_a: assert property ($rose(rdata_oe) |-> $past(rd_go, 4)) else $error("stray output");
	oe_burst_a: assert property ($fell(rdata_oe) |-> $past(rdata_oe, 2)) else $error("short burst");
	released_zero_a: assert property (!rdata_oe |-> rdata == '0) else $error("data while off");
	echo_order_a: assert property (rd_go |-> ##4 echo_clock_comp ##1 echo_clock_true) else $error("echo");
	echo_anti_a: assert property ($rose(echo_clock_true) |-> !echo_clock_comp) else $error("echo phase");
	mask_idle_a: assert property (!$past(wr_go, 2) && !$past(wr_go, 3) |-> &nibble_write_mask_n)
		else $error("mask off slot");
	sel_phase_a: assert property (!load_select_n |-> k) else $error("select phase");
	clk_pair_a: assert property (k_n == !k && c == k) else $error("clock pair");
	cover property (rd_go);
	cover property (wr_go ##2 rd_go);
	cover property (rd_go ##2 rd_go);
endmodule : dsio_assertions

/* tb/ddr_separate_io_sram_burst2_port_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ddr_separate_io_sram_burst2_port_tb
	import dsio_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rst_h = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [DSIO_ADDR_W-1:0] cmd_addr = '0;
	logic [15:0] cd = '0;
	logic [3:0] cm = 4'hF;
	logic rd_ready = 1'b1;
	logic cmd_ready;
	logic rd_valid;
	logic [15:0] rd_data;
	logic cal_done;
	logic dll_locked;
	logic [15:0] mem [256];
	logic [15:0] exp_q [$];
	int n_fail = 0;
	int comparisons = 0;
	bit ok;
	dsio_if dsio_if_i ();
	always #12.5 clk = ~clk;
	dsio_host #(.USE_OUT_CLK(1'b1), .DEPTH(32)) dsio_host_i (.ref_clk_i(clk), .rst_i(rst | rst_h),
		.bus(dsio_if_i), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write),
		.cmd_addr_i(cmd_addr), .cmd_wdata0_i(cd[7:0]), .cmd_wdata1_i(cd[15:8]), .cmd_mask0_n_i(cm[1:0]),
		.cmd_mask1_n_i(cm[3:2]), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data));
	dsio_device #(.ADDR_W(8), .CAL_CYCLES(4), .RELOCK_CYCLES(4)) dsio_device_i (.ref_clk_i(clk),
		.rst_i(rst), .bus(dsio_if_i), .cal_done_o(cal_done), .dll_locked_o(dll_locked));
	dsio_assertions dsio_assertions_i (.ref_clk_i(clk), .rst_i(rst | rst_h), .k(dsio_if_i.k),
		.k_n(dsio_if_i.k_n), .c(dsio_if_i.c), .load_select_n(dsio_if_i.load_select_n), .rw(dsio_if_i.rw),
		.nibble_write_mask_n(dsio_if_i.nibble_write_mask_n), .rdata(dsio_if_i.rdata),
		.rdata_oe(dsio_if_i.rdata_oe), .echo_clock_true(dsio_if_i.echo_clock_true),
		.echo_clock_comp(dsio_if_i.echo_clock_comp));

	// Valid stays up between calls; callers drop it, avoiding a double assignment per step
	task automatic issue(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] m);
		cmd_write = wr;
		cmd_addr = {13'h0000, a};
		cd = d;
		cm = m;
		cmd_valid = 1'b1;
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++)
		begin
			// Let ready settle after the new write flag before looking
			#1;
			ok = (cmd_ready === 1'b1);
			@(posedge clk);
			#2;
		end
		for (int j = 0; j < 4; j++)
			if (ok && wr && !m[j])
				mem[a][j*4 +: 4] = d[j*4 +: 4];
		if (ok && !wr)
			exp_q.push_back(mem[a]);
	endtask : issue

	task automatic drain;
		cmd_valid = 1'b0;
		for (int i = 0; i < 400 && exp_q.size() > 0; i++)
			@(posedge clk);
		#2;
		`CHK(exp_q.size(), 0)
	endtask : drain

	task automatic print_verdict;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	always @(posedge clk)
	begin
		if (rd_valid === 1'b1 && rd_ready)
		begin
			`CHK(rd_data, exp_q[0])
			void'(exp_q.pop_front());
		end
	end

	initial
	begin
		repeat (5) @(posedge clk);
		#2 rst = 1'b0;
		`CHK(cal_done, 1'b0)
		for (int a = 0; a < 32; a++)
		begin
			issue(1'b1, a[7:0], {a[7:0] ^ 8'hC3, a[7:0]}, 4'h0);
			`CHK(ok, 1'b1)
		end
		issue(1'b1, 8'h28, 16'h0000, 4'h0);
		`CHK(ok, 1'b1)
		for (int m = 0; m < 16; m++)
		begin
			issue(1'b1, 8'h28, {4{m[3:0] + 4'h1}}, m[3:0]);
			`CHK(ok, 1'b1)
			issue(1'b0, 8'h28, 16'h0000, 4'hF);
			`CHK(ok, 1'b1)
		end
		drain();
		`CHK(cal_done, 1'b1)
		$display("test masks done");
		rd_ready = 1'b0;
		for (int a = 0; a < 32; a++)
		begin
			issue(1'b0, a[7:0], 16'h0000, 4'hF);
			`CHK(ok, 1'b1)
		end
		issue(1'b0, 8'h00, 16'h0000, 4'hF);
		`CHK(ok, 1'b0)
		cmd_valid = 1'b0;
		rd_ready = 1'b1;
		drain();
		$display("test fifo done");
		rst_h = 1'b1;
		repeat (20) @(posedge clk);
		#2;
		`CHK(dll_locked, 1'b0)
		rst_h = 1'b0;
		repeat (20) @(posedge clk);
		#2;
		`CHK(dll_locked, 1'b1)
		$display("test clock loss done");
		print_verdict();
	end
endmodule : ddr_separate_io_sram_burst2_port_tb
